/* include/gated_timer_pkg.sv */
// package of offsets, field positions, reset values and types for the gated sixteen bit timer
package gated_timer_pkg;

  // ----------------------------------------------------------------
  // register byte addresses (one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_GATE_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TC_SOURCE_MSB = 7;  // clock source select, bits 7:6
  localparam int TC_SOURCE_LSB = 6;
  localparam int TC_PRESCALE_MSB = 5;  // prescale select, bits 5:4
  localparam int TC_PRESCALE_LSB = 4;
  localparam int TC_OSC_ENABLE_BIT = 3;  // secondary oscillator enable
  localparam int TC_SYNC_BIT = 2;  // 1 = external clock not resynchronised
  localparam int TC_RUN_BIT = 0;  // run bit
  localparam int GC_ENABLE_BIT = 7;  // gate enable
  localparam int GC_POLARITY_BIT = 6;  // gate polarity
  localparam int GC_LEVEL_BIT = 2;  // gate level, read only
  localparam int IRQ_OVERFLOW_BIT = 0;  // overflow flag

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] GATE_CONTROL_RESET = 8'h00;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // timing: instruction clock is the system clock divided by four
  // ----------------------------------------------------------------
  localparam int INSTR_CLOCK_DIVIDE = 4;

  // clock source encoding
  typedef enum logic [1:0] {
    SRC_INSTR = 2'h0,
    SRC_SYSTEM = 2'h1,
    SRC_EXTERNAL = 2'h2,
    SRC_LOW_FREQ = 2'h3
  } clock_source_t;

  // software control fields of the timer
  typedef struct packed {
    clock_source_t source;
    logic [1:0] prescaleSelect;
    logic secondaryOscEnable;
    logic syncSelect;
    logic runBit;
    logic gateEnable;
    logic gatePolarity;
  } timer_ctrl_t;

  // synchronised external levels
  typedef struct packed {
    logic extClock;
    logic lowFreqOsc;
    logic oscInput;
    logic gate;
  } pin_levels_t;

endpackage

/* design/gated_sixteen_bit_timer.sv */
// gated sixteen bit timer with classic wishbone register slave
`timescale 1ns/100ps
module gated_sixteen_bit_timer
  import gated_timer_pkg::*;
#(
  parameter int ADDR_WIDTH = 8  // wishbone byte address width
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [ADDR_WIDTH-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic externalClockPin,
  input wire logic gateInput,
  input wire logic lowFreqInternalOsc,
  input wire logic oscInputPin,
  output logic oscOutputPin,
  output logic oscOutputEnable,
  output logic irq
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (ADDR_WIDTH < 5 || ADDR_WIDTH > 8) begin : g_bad_width
    $error("ADDR_WIDTH must lie between 5 and 8");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0] count_reg;  // live count
  logic [15:0] count_next;
  logic [2:0] prescale_reg;  // hidden prescale counter
  logic [2:0] prescale_next;
  logic [1:0] quarter_reg;  // instruction clock divider
  timer_ctrl_t ctrl_reg;  // software control fields
  pin_levels_t meta_reg;  // first synchroniser stage
  pin_levels_t pins_reg;  // second synchroniser stage
  pin_levels_t pinsLast_reg;  // previous synchronised level, for edges
  logic armed_reg;  // falling edge seen since last disarm
  logic runLast_reg;  // run bit one cycle ago
  logic extPending_reg;  // resynchronised pin edge waiting for phase
  logic overflowFlag_reg;  // sticky overflow status
  logic overflowMask_reg;  // interrupt mask
  logic busReq;  // new wishbone access this cycle
  logic busWrite;
  logic [7:0] byteAdr;  // address widened to eight bits
  logic wrCountLow;
  logic wrCountHigh;
  logic extRise;
  logic extFall;
  logic lowRise;
  logic instrTick;
  logic sourceTick;  // one tick of the selected source
  logic prescaleTick;  // one tick after the prescaler
  logic gateOk;
  logic countEnable;
  logic wrapping;
  logic [2:0] divideLast;  // terminal value of the prescaler
  logic [7:0] readByte;
  logic readHit;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // every access answers after one cycle; ack gap prevents double take
  assign busReq = wbCyc && wbStb && !wbAck;
  assign busWrite = busReq && wbWe && wbSel[0];
  assign byteAdr = 8'(wbAdr);
  assign wrCountLow = busWrite && (byteAdr == ADDR_COUNT_LOW);
  assign wrCountHigh = busWrite && (byteAdr == ADDR_COUNT_HIGH);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // every outside level passes two flops before any logic looks at it
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      pins_reg <= '0;
      pinsLast_reg <= '0;
    end else begin
      meta_reg <= '{extClock: externalClockPin, lowFreqOsc: lowFreqInternalOsc,
                    oscInput: oscInputPin, gate: gateInput};
      pins_reg <= meta_reg;
      pinsLast_reg <= pins_reg;
    end
  end

  // secondary oscillator replaces the pin as external source when enabled
  always_comb begin
    if (ctrl_reg.secondaryOscEnable) begin
      extRise = pins_reg.oscInput && !pinsLast_reg.oscInput;
      extFall = !pins_reg.oscInput && pinsLast_reg.oscInput;
    end else begin
      extRise = pins_reg.extClock && !pinsLast_reg.extClock;
      extFall = !pins_reg.extClock && pinsLast_reg.extClock;
    end
  end
  assign lowRise = pins_reg.lowFreqOsc && !pinsLast_reg.lowFreqOsc;

  // ----------------------------------------------------------------
  // secondary oscillator amplifier
  // ----------------------------------------------------------------
  // inverting drive back to the crystal; free of the run bit so it
  // keeps going whether or not the counter is enabled
  always_ff @(posedge clk) begin
    if (reset) begin
      oscOutputPin <= 1'b0;
      oscOutputEnable <= 1'b0;
    end else begin
      oscOutputEnable <= ctrl_reg.secondaryOscEnable;
      oscOutputPin <= ctrl_reg.secondaryOscEnable && !pins_reg.oscInput;
    end
  end

  // ----------------------------------------------------------------
  // instruction clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      quarter_reg <= '0;
    end else begin
      quarter_reg <= quarter_reg + 2'h1;
    end
  end
  assign instrTick = (quarter_reg == 2'(INSTR_CLOCK_DIVIDE - 1));

  // ----------------------------------------------------------------
  // falling edge arming for external counting
  // ----------------------------------------------------------------
  // a rise is only counted after a fall; disarmed on enable, disable
  // and count writes so a pin held high never counts spuriously
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_reg <= 1'b0;
      runLast_reg <= 1'b0;
    end else begin
      runLast_reg <= ctrl_reg.runBit;
      if (wrCountLow || wrCountHigh || (ctrl_reg.runBit != runLast_reg)) begin
        armed_reg <= 1'b0;
      end else if (extFall) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // resynchronised mode holds the edge until the instruction phase; an edge
  // in the tick cycle itself is counted directly and must not wait as well
  always_ff @(posedge clk) begin
    if (reset) begin
      extPending_reg <= 1'b0;
    end else if (ctrl_reg.syncSelect || !ctrl_reg.runBit || (ctrl_reg.source != SRC_EXTERNAL)
                 || wrCountLow || wrCountHigh) begin
      extPending_reg <= 1'b0;
    end else if (instrTick) begin
      extPending_reg <= 1'b0;
    end else if (extRise && armed_reg) begin
      extPending_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ctrl_reg.source)
      SRC_INSTR: sourceTick = instrTick;
      SRC_SYSTEM: sourceTick = 1'b1;
      SRC_EXTERNAL: begin
        if (ctrl_reg.syncSelect) begin
          sourceTick = extRise && armed_reg;
        end else begin
          sourceTick = instrTick && (extPending_reg || (extRise && armed_reg));
        end
      end
      SRC_LOW_FREQ: sourceTick = lowRise;
    endcase
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // divide by 2^select: terminal value is 0, 1, 3 or 7
  assign divideLast = 3'((4'h1 << ctrl_reg.prescaleSelect) - 4'h1);
  assign gateOk = !ctrl_reg.gateEnable || (pins_reg.gate == ctrl_reg.gatePolarity);
  assign countEnable = ctrl_reg.runBit && gateOk;
  // at or past the terminal, so a smaller select takes effect at once
  assign prescaleTick = countEnable && sourceTick && (prescale_reg >= divideLast);

  always_comb begin
    prescale_next = prescale_reg;
    if (wrCountLow || wrCountHigh) begin
      prescale_next = PRESCALE_RESET;
    end else if (countEnable && sourceTick) begin
      prescale_next = (prescale_reg >= divideLast) ? PRESCALE_RESET : prescale_reg + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prescale_reg <= PRESCALE_RESET;
    end else begin
      prescale_reg <= prescale_next;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // a byte write takes priority over an increment in the same cycle
  assign wrapping = prescaleTick && (count_reg == COUNT_MAX) && !wrCountLow && !wrCountHigh;

  always_comb begin
    count_next = count_reg;
    if (wrCountLow) begin
      count_next[7:0] = wbDatI[7:0];
    end else if (wrCountHigh) begin
      count_next[15:8] = wbDatI[7:0];
    end else if (prescaleTick) begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= '{source: clock_source_t'(TIMER_CONTROL_RESET[TC_SOURCE_MSB:TC_SOURCE_LSB]),
                    prescaleSelect: TIMER_CONTROL_RESET[TC_PRESCALE_MSB:TC_PRESCALE_LSB],
                    secondaryOscEnable: TIMER_CONTROL_RESET[TC_OSC_ENABLE_BIT],
                    syncSelect: TIMER_CONTROL_RESET[TC_SYNC_BIT],
                    runBit: TIMER_CONTROL_RESET[TC_RUN_BIT],
                    gateEnable: GATE_CONTROL_RESET[GC_ENABLE_BIT],
                    gatePolarity: GATE_CONTROL_RESET[GC_POLARITY_BIT]};
    end else if (busWrite && byteAdr == ADDR_TIMER_CONTROL) begin
      ctrl_reg.source <= clock_source_t'(wbDatI[TC_SOURCE_MSB:TC_SOURCE_LSB]);
      ctrl_reg.prescaleSelect <= wbDatI[TC_PRESCALE_MSB:TC_PRESCALE_LSB];
      ctrl_reg.secondaryOscEnable <= wbDatI[TC_OSC_ENABLE_BIT];
      ctrl_reg.syncSelect <= wbDatI[TC_SYNC_BIT];
      ctrl_reg.runBit <= wbDatI[TC_RUN_BIT];
    end else if (busWrite && byteAdr == ADDR_GATE_CONTROL) begin
      ctrl_reg.gateEnable <= wbDatI[GC_ENABLE_BIT];
      ctrl_reg.gatePolarity <= wbDatI[GC_POLARITY_BIT];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // a rollover in the clearing cycle wins over the write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      overflowFlag_reg <= 1'b0;
    end else if (wrapping) begin
      overflowFlag_reg <= 1'b1;
    end else if (busWrite && byteAdr == ADDR_IRQ_STATUS && wbDatI[IRQ_OVERFLOW_BIT]) begin
      overflowFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      overflowMask_reg <= 1'b0;
    end else if (busWrite && byteAdr == ADDR_IRQ_MASK) begin
      overflowMask_reg <= wbDatI[IRQ_OVERFLOW_BIT];
    end
  end

  // registered level, so it lags the flag by one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= overflowFlag_reg && overflowMask_reg;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // the prescaler has no read path; unmapped addresses read zero
  always_comb begin
    readByte = 8'h00;
    readHit = 1'b1;
    unique case (byteAdr)
      ADDR_COUNT_LOW: readByte = count_reg[7:0];
      ADDR_COUNT_HIGH: readByte = count_reg[15:8];
      ADDR_TIMER_CONTROL: begin
        readByte[TC_SOURCE_MSB:TC_SOURCE_LSB] = ctrl_reg.source;
        readByte[TC_PRESCALE_MSB:TC_PRESCALE_LSB] = ctrl_reg.prescaleSelect;
        readByte[TC_OSC_ENABLE_BIT] = ctrl_reg.secondaryOscEnable;
        readByte[TC_SYNC_BIT] = ctrl_reg.syncSelect;
        readByte[TC_RUN_BIT] = ctrl_reg.runBit;
      end
      ADDR_GATE_CONTROL: begin
        readByte[GC_ENABLE_BIT] = ctrl_reg.gateEnable;
        readByte[GC_POLARITY_BIT] = ctrl_reg.gatePolarity;
        readByte[GC_LEVEL_BIT] = pins_reg.gate;
      end
      ADDR_IRQ_STATUS: readByte[IRQ_OVERFLOW_BIT] = overflowFlag_reg;
      ADDR_IRQ_MASK: readByte[IRQ_OVERFLOW_BIT] = overflowMask_reg;
      default: readHit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // wishbone answer
  // ----------------------------------------------------------------
  // ack for one cycle after every request, mapped or not, so a stray
  // address never hangs the master
  always_ff @(posedge clk) begin
    if (reset) begin
      wbAck <= 1'b0;
      wbDatO <= '0;
    end else begin
      wbAck <= busReq;
      if (busReq) begin
        wbDatO <= readHit ? {24'h000000, readByte} : 32'h00000000;
      end
    end
  end

endmodule  // gated_sixteen_bit_timer

/* verification/timer_checker.sv */
// checker of the bus, interrupt and oscillator port relations of the gated timer
`timescale 1ns/100ps
module timer_checker
  import gated_timer_pkg::*;
#(
  parameter int ADDR_WIDTH = 8  // byte address width, handed on by the bind
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [ADDR_WIDTH-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  input wire logic externalClockPin,
  input wire logic gateInput,
  input wire logic lowFreqInternalOsc,
  input wire logic oscInputPin,
  input wire logic oscOutputPin,
  input wire logic oscOutputEnable,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // assertions, all in the system clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire logic req = wbCyc && wbStb && !wbAck;  // request being taken this edge
  chk_ack_next_cycle: assert property (req |=> wbAck)
    else $error("ack missing one cycle after request");
  chk_ack_single_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  chk_ack_needs_request: assert property ($rose(wbAck) |-> $past(wbCyc && wbStb))
    else $error("ack without a request");
  chk_upper_bits_zero: assert property (wbAck |-> wbDatO[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_unmapped_read_zero: assert property (wbAck && !$past(wbWe) && $past(wbAdr) > ADDR_IRQ_MASK |-> wbDatO == 32'h0)
    else $error("unmapped read not zero");
  chk_read_data_holds: assert property (!req |=> $stable(wbDatO))
    else $error("read data changed without a request");
  chk_mask_clear_irq: assert property (req && wbWe && wbSel[0] && wbAdr == ADDR_IRQ_MASK && !wbDatI[0] |=> ##1 !irq)
    else $error("irq still high after mask cleared");
  chk_osc_enable_follows: assert property (req && wbWe && wbSel[0] && wbAdr == ADDR_TIMER_CONTROL
    |=> ##1 oscOutputEnable == $past(wbDatI[TC_OSC_ENABLE_BIT], 2))
    else $error("oscillator enable does not follow its bit");
  chk_osc_pin_enabled: assert property (oscOutputPin |-> oscOutputEnable)
    else $error("oscillator driven while disabled");
  chk_osc_pin_inverts: assert property (oscOutputEnable |-> oscOutputPin == !$past(oscInputPin, 3))
    else $error("oscillator drive is not the inverted input");
  // main scenarios
  cover property ($rose(irq));
  cover property ($rose(oscOutputEnable));
  cover property (wbAck && wbDatO[7:0] != 8'h00);
endmodule  // timer_checker

bind gated_sixteen_bit_timer timer_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_checker (.clk(clk), .reset(reset),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
  .wbAck(wbAck), .externalClockPin(externalClockPin), .gateInput(gateInput), .lowFreqInternalOsc(lowFreqInternalOsc),
  .oscInputPin(oscInputPin), .oscOutputPin(oscOutputPin), .oscOutputEnable(oscOutputEnable), .irq(irq));

/* verification/ext_source_model.sv */
// model of the external count clock, gate source and free running oscillators
`timescale 1ns/100ps
module ext_source_model (
  input wire logic clk,
  input wire logic freeRun,
  input wire logic manualLevel,
  input wire logic gateLevel,
  output logic externalClockPin,
  output logic gateInput,
  output logic lowFreqInternalOsc,
  output logic oscInputPin
);
  // ----------------------------------------------------------------
  // waveforms
  // ----------------------------------------------------------------
  logic [3:0] phase = 4'h0;  // free running phase of the oscillators
  // phase advances every system cycle; period eight keeps window counts exact
  always @(posedge clk) begin
    phase <= phase + 4'h1;
  end
  // pin clock stands still at the bench's level unless a frame runs
  assign externalClockPin = freeRun ? phase[2] : manualLevel;
  assign gateInput = gateLevel;
  assign lowFreqInternalOsc = ~phase[2];
  assign oscInputPin = phase[3];
endmodule  // ext_source_model

/* verification/testbench.sv */
// self-checking bench of the gated sixteen bit timer over classic wishbone
`timescale 1ns/100ps
module testbench;
  import gated_timer_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck, externalClockPin, gateInput, lowFreqInternalOsc, oscInputPin, oscOutputPin, oscOutputEnable, irq;
  logic freeRun = 1'b1, manualLevel = 1'b0, gateLevel = 1'b0;  // far side controls
  int n_fail = 0, n_checks = 0, cycles = 0;
  logic [7:0] junk;
  logic [7:0] regAddr [6] = '{ADDR_COUNT_LOW, ADDR_COUNT_HIGH, ADDR_TIMER_CONTROL, ADDR_GATE_CONTROL,
    ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  gated_sixteen_bit_timer u_dut (.clk(clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .externalClockPin(externalClockPin), .gateInput(gateInput), .lowFreqInternalOsc(lowFreqInternalOsc),
    .oscInputPin(oscInputPin), .oscOutputPin(oscOutputPin), .oscOutputEnable(oscOutputEnable), .irq(irq));
  ext_source_model u_far (.clk(clk), .freeRun(freeRun), .manualLevel(manualLevel), .gateLevel(gateLevel),
    .externalClockPin(externalClockPin), .gateInput(gateInput), .lowFreqInternalOsc(lowFreqInternalOsc),
    .oscInputPin(oscInputPin));
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled, then released
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [7:0] rd);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'h1;
    wbDatI <= {24'h0, dat};
    do @(posedge clk); while (wbAck !== 1'b1);
    rd = wbDatO[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat, junk);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, adr, 8'h00, v);
    check(v, exp);
  endtask
  // counts seen in a window of exactly 96 cycles between two low byte reads
  task automatic delta(input logic [7:0] ctl, input logic [7:0] exp);
    logic [7:0] a, b;
    wr(ADDR_TIMER_CONTROL, ctl);
    repeat (8) @(posedge clk);
    bus(1'b0, ADDR_COUNT_LOW, 8'h00, a);
    repeat (93) @(posedge clk);
    bus(1'b0, ADDR_COUNT_LOW, 8'h00, b);
    check(b - a, exp);
  endtask
  // hang guard, well above the roughly twenty thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    foreach (regAddr[i]) rd(regAddr[i], 8'h00);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h34);
    wr(ADDR_COUNT_HIGH, 8'h12);
    rd(ADDR_COUNT_LOW, 8'h34);
    rd(ADDR_COUNT_HIGH, 8'h12);
    delta(8'h40, 8'h00);
    // system and instruction clock against every prescale setting
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        delta({s[0] ? SRC_INSTR : SRC_SYSTEM, p[1:0], 4'h1}, 8'(96 >> (p + 2 * s)));
      end
    end
    delta(8'hc1, 8'd12);
    delta(8'h81, 8'd12);
    delta(8'h95, 8'd6);
    // rise without a prior fall is not counted after a count write
    freeRun <= 1'b0;
    wr(ADDR_TIMER_CONTROL, 8'h85);
    wr(ADDR_COUNT_LOW, 8'h00);
    foreach (regAddr[i]) begin
      manualLevel <= ~i[0];
      repeat (8) @(posedge clk);
    end
    rd(ADDR_COUNT_LOW, 8'h02);
    freeRun <= 1'b1;
    // gate against both polarities and both levels
    for (int k = 0; k < 4; k++) begin
      gateLevel <= k[0];
      wr(ADDR_GATE_CONTROL, {1'b1, k[1], 6'h00});
      rd(ADDR_GATE_CONTROL, {1'b1, k[1], 3'h0, k[0], 2'h0});
      delta(8'h41, (k[0] == k[1]) ? 8'd96 : 8'd0);
    end
    wr(ADDR_GATE_CONTROL, 8'h00);
    // rollover sets the sticky flag and raises the unmasked interrupt
    wr(ADDR_TIMER_CONTROL, 8'h40);
    wr(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_COUNT_LOW, 8'hf0);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_IRQ_MASK, 8'h01);
    check({7'h0, irq}, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'h41);
    repeat (30) @(posedge clk);
    wr(ADDR_TIMER_CONTROL, 8'h40);
    rd(ADDR_IRQ_STATUS, 8'h01);
    rd(ADDR_COUNT_HIGH, 8'h00);
    check({7'h0, irq}, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    check({7'h0, irq}, 8'h00);
    wr(ADDR_IRQ_STATUS, 8'h01);
    rd(ADDR_IRQ_STATUS, 8'h00);
    // secondary oscillator has an enable of its own
    wr(ADDR_TIMER_CONTROL, 8'h08);
    repeat (2) @(posedge clk);
    check({7'h0, oscOutputEnable}, 8'h01);
    rd(ADDR_TIMER_CONTROL, 8'h08);
    // start-up wait: clear the flag, preload, flag after 1024 crystal edges
    wr(ADDR_TIMER_CONTROL, 8'h8c);
    wr(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'hfc);
    wr(ADDR_TIMER_CONTROL, 8'h8d);
    repeat (16000) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 8'h00);
    repeat (600) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 8'h01);
    // a count write restarts the hidden divide by eight: one step in 14 cycles
    wr(ADDR_TIMER_CONTROL, 8'h71);
    wr(ADDR_COUNT_LOW, 8'h00);
    repeat (12) @(posedge clk);
    rd(ADDR_COUNT_LOW, 8'h01);
    // reset in mid-run clears the count and stops the timer
    wr(ADDR_TIMER_CONTROL, 8'h49);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_COUNT_LOW, 8'h00);
    rd(ADDR_TIMER_CONTROL, 8'h00);
    check({7'h0, oscOutputEnable}, 8'h00);
    end_of_test();
  end
endmodule  // testbench
